// ### hw/asop_core.sv
// Sample capture, saturation, pipeline, two-entry buffer and output drivers of the converter.
// Function
// RULE1: Sample input on each falling conversion clock edge.
// RULE2: Power down stops conversion, floats outputs.
// RULE3: Drive data only when enable and power-down low.
// RULE4: Ten bit word, bit zero least significant.
// RULE5: New word shortly after each falling edge.
// RULE6: Straight binary code, rising with input.
// RULE7: Conversion clock at most 15 MSPS guaranteed.
// RULE8: Out-of-range input saturates, never wraps.
// RULE9: Fixed parameterisable sample-to-output latency.
`timescale 1ns/10ps
`default_nettype none
module asop_core #(
   parameter int unsigned LATENCY = asop_pkg::LATENCY
) (
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                rstn,
   // Conversion clock and controls from the capture side (pins)
   input  wire logic                conv_clk_pin,
   input  wire logic                power_down_pin,
   input  wire logic                output_enable_n,
   // Quantised analog input
   input  wire asop_pkg::asop_raw_t raw_in,
   // Data output pins
   output logic [9:0]               data_out,
   output logic                     data_out_oe,
   // Stream view of the buffer output
   output logic                     smp_valid,
   input  wire logic                smp_ready,
   output logic                     buf_full,
   output logic [9:0]               smp_data
);
   // ==========================================================
   // Pin synchronisers: three stages, a change counts when stages two and three agree.
   // Control stages reset to their disabling level, so the pins float until both controls are seen low.
   // The clock stage resets low and only a fall after a seen high level counts, so reset fakes no sample.
   logic [2:0] clk_sync_ff, pd_sync_ff, oen_sync_ff;
   logic       clk_lvl_ff, pd_lvl_ff, oen_lvl_ff;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         clk_sync_ff <= 3'h0;
         pd_sync_ff  <= 3'h7;
         oen_sync_ff <= 3'h7;
      end else begin
         clk_sync_ff <= {clk_sync_ff[1:0], conv_clk_pin};
         pd_sync_ff  <= {pd_sync_ff[1:0], power_down_pin};
         oen_sync_ff <= {oen_sync_ff[1:0], output_enable_n};
      end
   end
   wire clk_agree = clk_sync_ff[1] == clk_sync_ff[2];
   wire pd_agree  = pd_sync_ff[1] == pd_sync_ff[2];
   wire oen_agree = oen_sync_ff[1] == oen_sync_ff[2];
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         clk_lvl_ff <= 1'b0;
         pd_lvl_ff  <= 1'b1;
         oen_lvl_ff <= 1'b1;
      end else begin
         if (clk_agree) clk_lvl_ff <= clk_sync_ff[2];
         if (pd_agree)  pd_lvl_ff  <= pd_sync_ff[2];
         if (oen_agree) oen_lvl_ff <= oen_sync_ff[2];
      end
   end

   // ==========================================================
   // Sampling on falling conversion clock edge, suppressed in power down.
   wire fall_evt = clk_lvl_ff && clk_agree && !clk_sync_ff[2] && !pd_lvl_ff; // RULE1 RULE2

   // Straight binary with clamping: out-of-range never wraps.
   function automatic logic [9:0] sat_code(input asop_pkg::asop_raw_t r);
      if (r.over)       sat_code = asop_pkg::CODE_MAX; // RULE8
      else if (r.under) sat_code = asop_pkg::CODE_MIN; // RULE8
      else              sat_code = r.code;             // RULE6
   endfunction : sat_code
   wire [9:0] sampled = sat_code(raw_in);

   // ==========================================================
   // Fixed latency pipeline of sample events.
   // The valid bit travels beside the word, so a stage only loads when a real sample passes.
   logic [9:0] pipe_ff [LATENCY];
   logic [LATENCY-1:0] pv_ff;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pv_ff <= '0;
         for (int i = 0; i < LATENCY; i++) pipe_ff[i] <= asop_pkg::DATA_RST;
      end else begin
         pv_ff[0]   <= fall_evt; // RULE9
         pipe_ff[0] <= fall_evt ? sampled : pipe_ff[0];
         for (int i = 1; i < LATENCY; i++) begin
            pv_ff[i]   <= pv_ff[i-1];
            pipe_ff[i] <= pv_ff[i-1] ? pipe_ff[i-1] : pipe_ff[i];
         end
      end
   end
   wire       in_v = pv_ff[LATENCY-1];
   wire [9:0] in_d = pipe_ff[LATENCY-1];

   // ==========================================================
   // Two-entry buffer. A stalled reader keeps both words; a third arrival while full is
   // dropped because the pin side has no means of back-pressure.
   logic [9:0] mem_ff [2];
   logic       wp_ff, rp_ff;
   logic [1:0] cnt_ff;
   wire        in_rdy = cnt_ff != 2'h2;
   wire        do_wr  = in_v && in_rdy;
   wire        do_rd  = (cnt_ff != 2'h0) && smp_ready;
   wire [1:0]  nxt_cnt = cnt_ff + {1'b0, do_wr} - {1'b0, do_rd};
   // The next head comes from the incoming word when it lands in the slot that becomes the head,
   // so the stream word can leave from a register without an extra cycle of delay.
   wire        nxt_rp   = rp_ff ^ do_rd;
   wire [9:0]  nxt_head = (do_wr && (wp_ff == nxt_rp)) ? in_d : mem_ff[nxt_rp];
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mem_ff[0] <= asop_pkg::DATA_RST;
         mem_ff[1] <= asop_pkg::DATA_RST;
         wp_ff     <= 1'b0;
         rp_ff     <= 1'b0;
         cnt_ff    <= 2'h0;
      end else begin
         if (do_wr) mem_ff[wp_ff] <= in_d;
         if (do_wr) wp_ff <= ~wp_ff;
         if (do_rd) rp_ff <= ~rp_ff;
         cnt_ff <= nxt_cnt;
      end
   end

   // ==========================================================
   // Output registers: pins show the newest word, stream shows the buffer head.
   wire nxt_oe = !oen_lvl_ff && !pd_lvl_ff; // RULE3 RULE2
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         data_out    <= asop_pkg::DATA_RST;
         data_out_oe <= 1'b0;
         smp_valid   <= 1'b0;
         buf_full    <= 1'b0;
         smp_data    <= asop_pkg::DATA_RST;
      end else begin
         if (in_v) data_out <= in_d; // RULE4 RULE5
         data_out_oe <= nxt_oe;
         smp_valid   <= nxt_cnt != 2'h0;
         buf_full    <= nxt_cnt == 2'h2;
         smp_data    <= nxt_head;
      end
   end

   // ==========================================================
   // Checks
   // These watch the synchronised control levels, since the raw pins may change at any time.
   property p_oe_follows;
      @(posedge core_clk) disable iff (!rstn) (!oen_lvl_ff && !pd_lvl_ff) |=> data_out_oe;
   endproperty
   a_oe_follows: assert property (p_oe_follows) else $error("Output enable wrong."); // RULE3
   property p_oen_float;
      @(posedge core_clk) disable iff (!rstn) oen_lvl_ff |=> !data_out_oe;
   endproperty
   a_oen_float: assert property (p_oen_float) else $error("Driving while disabled."); // RULE3
   property p_pd_float;
      @(posedge core_clk) disable iff (!rstn) pd_lvl_ff |=> !data_out_oe;
   endproperty
   a_pd_float: assert property (p_pd_float) else $error("Driving in power down."); // RULE2
   property p_no_sample_pd;
      @(posedge core_clk) disable iff (!rstn) pd_lvl_ff |=> !pv_ff[0];
   endproperty
   a_no_sample_pd: assert property (p_no_sample_pd) else $error("Sampled in power down."); // RULE2
   property p_latency;
      @(posedge core_clk) disable iff (!rstn) fall_evt |-> ##(LATENCY) in_v;
   endproperty
   a_latency: assert property (p_latency) else $error("Latency wrong."); // RULE9
   property p_update;
      @(posedge core_clk) disable iff (!rstn) in_v |=> data_out == $past(in_d);
   endproperty
   a_update: assert property (p_update) else $error("Output not updated."); // RULE5
   property p_over;
      @(posedge core_clk) disable iff (!rstn) raw_in.over |-> sampled == asop_pkg::CODE_MAX;
   endproperty
   a_over: assert property (p_over) else $error("Over range not saturated."); // RULE8
   property p_under;
      @(posedge core_clk) disable iff (!rstn) (raw_in.under && !raw_in.over) |-> sampled == asop_pkg::CODE_MIN;
   endproperty
   a_under: assert property (p_under) else $error("Under range not saturated."); // RULE8
   property p_code;
      @(posedge core_clk) disable iff (!rstn) (!raw_in.under && !raw_in.over) |-> sampled == raw_in.code;
   endproperty
   a_code: assert property (p_code) else $error("Code not straight binary."); // RULE6
   property p_fall;
      @(posedge core_clk) disable iff (!rstn) fall_evt |-> $past(clk_lvl_ff) && !pd_lvl_ff;
   endproperty
   a_fall: assert property (p_fall) else $error("Sample without falling edge."); // RULE1
   property p_stall_hold;
      @(posedge core_clk) disable iff (!rstn) (smp_valid && !smp_ready) |=> smp_valid;
   endproperty
   a_stall_hold: assert property (p_stall_hold) else $error("Buffered word lost.");

   // A stalled reader must see the same head word until it accepts it.
   property p_head_stable;
      @(posedge core_clk) disable iff (!rstn) (smp_valid && !smp_ready) |=> $stable(smp_data);
   endproperty
   a_head_stable: assert property (p_head_stable) else $error("Head word changed while stalled.");
   property p_first_word;
      @(posedge core_clk) disable iff (!rstn) (in_v && !smp_valid) |=> smp_data == $past(in_d);
   endproperty
   a_first_word: assert property (p_first_word) else $error("Word into empty buffer not at head."); // RULE5
   property p_drop;
      @(posedge core_clk) disable iff (!rstn) (in_v && buf_full && !smp_ready) |=> buf_full;
   endproperty
   a_drop: assert property (p_drop) else $error("Full buffer changed on dropped word.");

   // The pin word holds between samples, so capture logic may take it at any time in the cycle.
   property p_hold;
      @(posedge core_clk) disable iff (!rstn) !in_v |=> $stable(data_out);
   endproperty
   a_hold: assert property (p_hold) else $error("Output word changed without a sample."); // RULE5

   // Coverage of the main scenarios: a sample, a full buffer, power down, a saturated sample and head.

   c_sample: cover property (@(posedge core_clk) disable iff (!rstn) fall_evt);
   c_full:   cover property (@(posedge core_clk) disable iff (!rstn) buf_full);
   c_pd:     cover property (@(posedge core_clk) disable iff (!rstn) $rose(pd_lvl_ff));
   c_sat:    cover property (@(posedge core_clk) disable iff (!rstn) fall_evt && raw_in.over);
   c_head:   cover property (@(posedge core_clk) disable iff (!rstn) smp_valid && smp_data == asop_pkg::CODE_MAX);
endmodule : asop_core
`default_nettype wire

// ### hw/asop_pkg.sv
// Package of constants and carrier types for the sample output port.
package asop_pkg;
   // ==========================================================
   // Sample format
   localparam int unsigned SAMPLE_W   = 10;
   localparam int unsigned RAW_W      = 12;
   localparam int unsigned LATENCY    = 2;
   localparam logic [9:0]  CODE_MAX   = 10'h3FF;
   localparam logic [9:0]  CODE_MIN   = 10'h000;
   localparam logic [9:0]  DATA_RST   = 10'h000;
   localparam int unsigned SYNC_DEPTH = 3;

   // ==========================================================
   // Converter front-end input: unsigned raw code plus range flags
   typedef struct packed {
      logic       over;
      logic       under;
      logic [9:0] code;
   } asop_raw_t;

   // Output pin group
   typedef struct packed {
      logic [9:0] data;
      logic       oe;
   } asop_pins_t;
endpackage : asop_pkg

// ### dv/asop_capture_model.sv
// Capture-side model that makes conversion clock pulses and grants reads.
`timescale 1ns/10ps
`default_nettype none
module asop_capture_model (
   // Clock
   input  wire logic core_clk,
   // Bench control
   input  wire logic fire,
   input  wire logic accept,
   // Pins toward the converter
   output logic      conv_clk_pin,
   output logic      smp_ready
);
   int cnt = 0;
   assign smp_ready = accept;
   // The low phase lasts four core cycles and the high phase at least five, so the converter's sync stages can follow.
   assign conv_clk_pin = !(cnt > 4);
   always @(posedge core_clk) begin
      if (cnt == 0 && fire) begin
         cnt <= 8;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule : asop_capture_model
`default_nettype wire

// ### dv/tb.sv
// Self-checking testbench for the converter sample output port.
`timescale 1ns/10ps
`default_nettype none
module tb;
   // ==========================================================
   // Signals
   logic core_clk = 0, rstn = 0, power_down_pin = 0, output_enable_n = 0;
   logic fire = 0, accept = 0, conv_clk_pin, smp_ready;
   asop_pkg::asop_raw_t raw_in = '0;
   logic [9:0] data_out, smp_data;
   logic data_out_oe, smp_valid, buf_full;
   int errors = 0, n_compared = 0;
   logic [11:0] tv [8] = '{12'h000, 12'h001, 12'h155, 12'h2AA, 12'h3FF, 12'h8AA, 12'h4AA, 12'hC55};
   logic [9:0] ex [8] = '{10'h000, 10'h001, 10'h155, 10'h2AA, 10'h3FF, 10'h3FF, 10'h000, 10'h3FF};
   always #12.5 core_clk = ~core_clk;
   asop_capture_model cap (.core_clk(core_clk), .fire(fire), .accept(accept),
      .conv_clk_pin(conv_clk_pin), .smp_ready(smp_ready));
   asop_core dut (.core_clk(core_clk), .rstn(rstn), .conv_clk_pin(conv_clk_pin),
      .power_down_pin(power_down_pin), .output_enable_n(output_enable_n), .raw_in(raw_in),
      .data_out(data_out), .data_out_oe(data_out_oe), .smp_valid(smp_valid),
      .smp_ready(smp_ready), .buf_full(buf_full), .smp_data(smp_data));
   // ==========================================================
   // Helpers
   task step(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask : step
   task results;
      $display("errors=%0d compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results
   task chk(input logic [9:0] got, input logic [9:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         errors++;
      end
   endtask : chk
   task chk_b(input logic got, input logic exp);
      chk({9'h000, got}, {9'h000, exp});
   endtask : chk_b
   // The input word is held for thirteen cycles, well past its capture point.
   task conv(input logic [11:0] v);
      raw_in = asop_pkg::asop_raw_t'(v);
      fire = 1;
      step(1);
      fire = 0;
      step(12);
   endtask : conv
   task wait_v;
      int i;
      for (i = 0; i < 30 && smp_valid !== 1'b1; i++) step(1);
      if (i == 30) begin
         errors++;
         results;
      end
   endtask : wait_v
   // ==========================================================
   // Scenarios
   task t_codes;
      for (int i = 0; i < 8; i++) begin
         conv(tv[i]);
         wait_v;
         chk(data_out, ex[i]);
         chk(smp_data, ex[i]);
         chk_b(data_out_oe, 1);
         accept = 1;
         step(1);
         accept = 0;
         chk_b(smp_valid, 0);
      end
   endtask : t_codes
   task t_power;
      power_down_pin = 1;
      step(8);
      chk_b(data_out_oe, 0);
      conv(12'h123);
      chk_b(smp_valid, 0);
      chk(data_out, 10'h3FF);
      power_down_pin = 0;
      step(8);
      chk_b(data_out_oe, 1);
      output_enable_n = 1;
      step(8);
      chk_b(data_out_oe, 0);
      output_enable_n = 0;
      step(8);
   endtask : t_power
   task t_buffer;
      conv(12'h011);
      conv(12'h022);
      conv(12'h033);
      chk_b(buf_full, 1);
      chk_b(smp_valid, 1);
      chk(data_out, 10'h033);
      chk(smp_data, 10'h011);
      accept = 1;
      step(1);
      chk(smp_data, 10'h022);
      chk_b(smp_valid, 1);
      step(1);
      accept = 0;
      chk_b(smp_valid, 0);
      chk_b(buf_full, 0);
   endtask : t_buffer
   // Three sync edges, the pipeline and one output edge pass between the pin falling and the new word.
   task t_latency;
      raw_in = asop_pkg::asop_raw_t'(12'h0A5);
      fire = 1;
      step(1);
      fire = 0;
      step(3 + asop_pkg::LATENCY);
      chk(data_out, 10'h033);
      step(1);
      chk(data_out, 10'h0A5);
      chk(smp_data, 10'h0A5);
      step(10);
      accept = 1;
      step(1);
      accept = 0;
      chk_b(smp_valid, 0);
   endtask : t_latency
   // A reset in mid-run empties the buffer and floats the pins until the controls resync.
   task t_reset;
      conv(12'h1E7);
      rstn = 0;
      step(2);
      chk(data_out, asop_pkg::DATA_RST);
      chk_b(data_out_oe, 0);
      chk_b(smp_valid, 0);
      chk_b(buf_full, 0);
      rstn = 1;
      step(5);
      chk_b(data_out_oe, 1);
      conv(12'h2C3);
      chk(data_out, 10'h2C3);
      chk(smp_data, 10'h2C3);
   endtask : t_reset
   initial begin
      step(4);
      rstn = 1;
      step(5);
      t_codes;
      t_power;
      t_buffer;
      t_latency;
      t_reset;
      results;
   end
endmodule : tb
`default_nettype wire
